//--- rtl/pcx_regs.svh
// register map, field positions and reset values of the port and crossbar block
// assumes a word-addressed slave: byte address is four times the index below
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define PCX_NPORTS 4
`define PCX_IDX_W 10

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define PCX_IDX_LATCH0 10'h080
`define PCX_LATCH_STRIDE 10'h010
`define PCX_IDX_DRIVE0 10'h0A4
`define PCX_IDX_KIND0 10'h0F1
`define PCX_CFG_STRIDE 10'h001
`define PCX_IDX_CROSSBAR_CONTROL_1 10'h0E2
`define PCX_BIT_REGION 2'h1

// ----------------------------------------------------------------
// crossbar_control_1 fields
// ----------------------------------------------------------------
`define PCX_CROSSBAR_CONTROL_1_WPUD 7
`define PCX_CROSSBAR_CONTROL_1_CROSSBAR_ENABLE 6
`define PCX_CROSSBAR_CONTROL_1_ROUTE_W 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCX_RST_LATCH 8'hFF
`define PCX_RST_KIND 8'hFF
`define PCX_RST_DRIVE 8'h00
`define PCX_RST_CROSSBAR_CONTROL_1 8'h00

`endif

//--- rtl/pcx_pkg.sv
// shared types of the port and crossbar block
// assumes nothing beyond the register header for numbers
package pcx_pkg;
	// one port byte or one register value
	typedef logic [7:0] pcx_byte_t;
	// word index on the register bus
	typedef logic [9:0] pcx_idx_t;
endpackage : pcx_pkg

//--- rtl/pcx_reg_if.sv
// carrier between the bus slave and the register file
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface pcx_reg_if;
	import pcx_pkg::*;
	logic take; // request accepted this cycle
	logic wr; // write takes effect this cycle
	logic we; // direction of current request
	logic tag; // latch view for read-modify-write reads
	pcx_idx_t idx; // word index
	pcx_byte_t wdat; // write data
	pcx_byte_t rdat; // read data from register file
	modport bus (output take, output wr, output we, output tag, output idx, output wdat, input rdat);
	modport regs (input take, input wr, input we, input tag, input idx, input wdat, output rdat);
endinterface : pcx_reg_if

//--- rtl/pcx_wb_slave.sv
// classic wishbone slave front end for the port register file
// assumes a single-cycle master holding its request until ack
`timescale 1ns/10ps
module pcx_wb_slave
	import pcx_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic wb_tga_i, // address tag: latch view
	input wire logic [11:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	pcx_reg_if.bus reg_o // towards register file
);
	logic req;
	logic ack_q;
	logic [31:0] dat_q;

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	assign req = wb_cyc_i & wb_stb_i;
	assign reg_o.take = req & ~ack_q;
	assign reg_o.wr = req & ack_q & wb_we_i & wb_sel_i[0]; // lane 0 holds the byte
	assign reg_o.we = wb_we_i;
	assign reg_o.tag = wb_tga_i;
	assign reg_o.idx = wb_adr_i[11:2];
	assign reg_o.wdat = wb_dat_i[7:0];

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// read data caught as the request is taken, upper bits zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h00000000;
		end else if (reg_o.take) begin
			dat_q <= {24'h000000, reg_o.rdat};
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_ack_o) |=> wb_ack_o) else $error("request not answered next cycle");
endmodule : pcx_wb_slave

//--- rtl/pcx_pin_cell.sv
// one port pin: driver, open-drain handling, weak pullup and read path
// assumes pin_i already synchronised to clk_i
`timescale 1ns/10ps
module pcx_pin_cell (
	input wire logic clk_i, // system clock, for checks only
	input wire logic rst_i, // synchronous reset, for checks only
	input wire logic latch_i, // output latch bit
	input wire logic digital_i, // input kind: 1 digital, 0 analog
	input wire logic push_pull_i, // drive mode: 1 push-pull, 0 open-drain
	input wire logic xbar_en_i, // crossbar enable
	input wire logic wpud_i, // weak pullup disable
	input wire logic periph_sel_i, // pin given to a peripheral
	input wire logic periph_dat_i, // peripheral output value
	input wire logic pin_i, // synchronised pin level
	output logic out_o, // pad output value
	output logic oe_o, // pad output enable
	output logic pullup_o, // weak pullup on
	output logic rd_o // level seen by a port read
);
	logic val;

	// ----------------------------------------------------------------
	// driver
	// ----------------------------------------------------------------
	// latch drives unless the crossbar gave the pin away
	assign val = periph_sel_i ? periph_dat_i : latch_i;
	// push-pull drives both levels, open-drain only low
	assign out_o = push_pull_i & val;
	assign oe_o = xbar_en_i & digital_i & (push_pull_i | ~val);
	// pullup only on open-drain digital pins not pulling low
	assign pullup_o = ~wpud_i & digital_i & ~push_pull_i & ~oe_o;
	// analog pins read as one, receiver off
	assign rd_o = digital_i ? pin_i : 1'b1;

	a_od_low_only: assert property (@(posedge clk_i) disable iff (rst_i)
		(oe_o && !push_pull_i) |-> !out_o) else $error("open-drain pin driven high");
	a_analog_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!digital_i |-> (!oe_o && !pullup_o && rd_o)) else $error("analog pin not quiet");
	a_pullup_rule: assert property (@(posedge clk_i) disable iff (rst_i)
		(push_pull_i || wpud_i) |-> !pullup_o) else $error("pullup on where it must be off");
	a_pullup_on: assert property (@(posedge clk_i) disable iff (rst_i)
		(!wpud_i && digital_i && !push_pull_i && latch_i && !periph_sel_i) |-> pullup_o)
		else $error("open-drain pullup missing");
	a_gpio_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		(xbar_en_i && digital_i && push_pull_i && !periph_sel_i) |-> (oe_o && out_o == latch_i))
		else $error("push-pull pin does not follow latch");
endmodule : pcx_pin_cell

//--- rtl/pcx_port_top.sv
// port latches, mode registers and crossbar control behind a wishbone slave
// assumes pad inputs are asynchronous; crossbar priority decode lives outside
//
// Function
// - A pin not given to a peripheral and not analog works as general-purpose input or output.
// - Each of the four ports has its own register, reachable as a byte or one bit at a time.
// - A write to a port register lands in the output latch, which sets each pin's output data.
// - An ordinary read of a port register returns the pin levels whatever the crossbar settings.
// - The listed arithmetic, logic, jump and single-bit instructions on a port are read-modify-write.
// - A read-modify-write reads the latch rather than the pins and writes the result back to the latch.
// - The crossbar is on only while its enable bit is one; otherwise every pin is an input.
// - All output drivers stay off while the crossbar is disabled.
// - With the pullup-disable bit zero, open-drain pins get a weak pullup unless driving low.
// - An input-kind bit of one makes a digital pin; zero makes an analog pin with driver, pullup and receiver off.
`timescale 1ns/10ps
`include "pcx_regs.svh"
module pcx_port_top
	import pcx_pkg::*;
#(
	parameter int NPORTS = `PCX_NPORTS // number of 8-bit ports
) (
	input wire logic clk_i, // system clock, 40 MHz
	input wire logic rst_i, // synchronous reset, active high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic wb_tga_i, // address tag: read the latch
	input wire logic [11:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte select
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic [NPORTS*8-1:0] pad_in_i, // pad levels, asynchronous
	output logic [NPORTS*8-1:0] pad_out_o, // pad output value
	output logic [NPORTS*8-1:0] pad_oe_o, // pad output enable
	output logic [NPORTS*8-1:0] pad_pullup_o, // weak pullup enable
	input wire logic [NPORTS*8-1:0] periph_sel_i, // pin given to a peripheral
	input wire logic [NPORTS*8-1:0] periph_dat_i, // peripheral output value
	output logic crossbar_enable_o, // crossbar enabled
	output logic [5:0] crossbar_routing_o // timer and counter routing bits
);
	localparam int NPINS = NPORTS * 8;

	pcx_reg_if reg_if ();

	logic [NPINS-1:0] pad_s1_q;
	logic [NPINS-1:0] pad_s2_q;
	logic [NPINS-1:0] latch_q;
	logic [NPINS-1:0] kind_q;
	logic [NPINS-1:0] drive_q;
	logic [NPINS-1:0] pin_rd;
	pcx_byte_t crossbar_control_1_q;
	logic [NPORTS-1:0] lat_hit;
	logic [NPORTS-1:0] bit_hit;
	logic [NPORTS-1:0] kind_hit;
	logic [NPORTS-1:0] drive_hit;
	logic crossbar_control_1_hit;
	logic bit_region;
	logic [2:0] bit_n;
	logic xbar_en;
	logic wpud;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	pcx_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_tga_i(wb_tga_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.reg_o(reg_if.bus)
	);

	// ----------------------------------------------------------------
	// pad synchroniser
	// ----------------------------------------------------------------
	// two stages before any logic reads the pads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
		end else begin
			pad_s1_q <= pad_in_i;
			pad_s2_q <= pad_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// bit region: index 0x100 plus the bit address, port sfr in bits 7:3
	assign bit_region = reg_if.idx[9:8] == `PCX_BIT_REGION;
	assign bit_n = reg_if.idx[2:0];
	assign crossbar_control_1_hit = reg_if.idx == `PCX_IDX_CROSSBAR_CONTROL_1;

	generate
		for (genvar p = 0; p < NPORTS; p++) begin : g_dec
			localparam logic [9:0] LAT_IDX = 10'(`PCX_IDX_LATCH0 + p * `PCX_LATCH_STRIDE);
			// byte and bit views of the same port latch
			assign lat_hit[p] = reg_if.idx == LAT_IDX;
			assign bit_hit[p] = bit_region && ({2'h0, reg_if.idx[7:3], 3'h0} == LAT_IDX);
			assign kind_hit[p] = reg_if.idx == 10'(`PCX_IDX_KIND0 + p * `PCX_CFG_STRIDE);
			assign drive_hit[p] = reg_if.idx == 10'(`PCX_IDX_DRIVE0 + p * `PCX_CFG_STRIDE);
		end
	endgenerate

	// ----------------------------------------------------------------
	// per-port registers
	// ----------------------------------------------------------------
	generate
		for (genvar p = 0; p < NPORTS; p++) begin : g_port
			// output latch: byte write, or single-bit write leaving others as latched
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					latch_q[p*8 +: 8] <= `PCX_RST_LATCH;
				end else if (reg_if.wr && lat_hit[p]) begin
					latch_q[p*8 +: 8] <= reg_if.wdat;
				end else if (reg_if.wr && bit_hit[p]) begin
					latch_q[p*8 + 32'(bit_n)] <= reg_if.wdat[0];
				end
			end

			// input kind: all digital after reset
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					kind_q[p*8 +: 8] <= `PCX_RST_KIND;
				end else if (reg_if.wr && kind_hit[p]) begin
					kind_q[p*8 +: 8] <= reg_if.wdat;
				end
			end

			// output drive mode: open-drain after reset
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					drive_q[p*8 +: 8] <= `PCX_RST_DRIVE;
				end else if (reg_if.wr && drive_hit[p]) begin
					drive_q[p*8 +: 8] <= reg_if.wdat;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// crossbar control
	// ----------------------------------------------------------------
	// enable, pullup disable and routing bits for the outside crossbar
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crossbar_control_1_q <= `PCX_RST_CROSSBAR_CONTROL_1;
		end else if (reg_if.wr && crossbar_control_1_hit) begin
			crossbar_control_1_q <= reg_if.wdat;
		end
	end

	assign xbar_en = crossbar_control_1_q[`PCX_CROSSBAR_CONTROL_1_CROSSBAR_ENABLE];
	assign wpud = crossbar_control_1_q[`PCX_CROSSBAR_CONTROL_1_WPUD];
	assign crossbar_enable_o = xbar_en;
	assign crossbar_routing_o = crossbar_control_1_q[`PCX_CROSSBAR_CONTROL_1_ROUTE_W-1:0];

	// ----------------------------------------------------------------
	// pin cells
	// ----------------------------------------------------------------
	generate
		for (genvar k = 0; k < NPINS; k++) begin : g_pin
			pcx_pin_cell u_cell (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.latch_i(latch_q[k]),
				.digital_i(kind_q[k]),
				.push_pull_i(drive_q[k]),
				.xbar_en_i(xbar_en),
				.wpud_i(wpud),
				.periph_sel_i(periph_sel_i[k]),
				.periph_dat_i(periph_dat_i[k]),
				.pin_i(pad_s2_q[k]),
				.out_o(pad_out_o[k]),
				.oe_o(pad_oe_o[k]),
				.pullup_o(pad_pullup_o[k]),
				.rd_o(pin_rd[k])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// plain reads see the pins, tagged reads see the latch
	always_comb begin
		reg_if.rdat = 8'h00;
		for (int p = 0; p < NPORTS; p++) begin
			if (lat_hit[p]) begin
				reg_if.rdat = reg_if.tag ? latch_q[p*8 +: 8] : pin_rd[p*8 +: 8];
			end
			if (bit_hit[p]) begin
				reg_if.rdat = {7'h00, reg_if.tag ? latch_q[p*8 + 32'(bit_n)] : pin_rd[p*8 + 32'(bit_n)]};
			end
			if (kind_hit[p]) begin
				reg_if.rdat = kind_q[p*8 +: 8];
			end
			if (drive_hit[p]) begin
				reg_if.rdat = drive_q[p*8 +: 8];
			end
		end
		if (crossbar_control_1_hit) begin
			reg_if.rdat = crossbar_control_1_q;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_write_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.wr && lat_hit[0]) |=> (latch_q[7:0] == $past(reg_if.wdat)))
		else $error("byte write did not reach the latch");

	a_bit_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.wr && bit_hit[0]) |=>
		(((latch_q[7:0] ^ $past(latch_q[7:0])) & ~(8'(8'h01 << $past(bit_n)))) == 8'h00)
		&& (latch_q[$past(bit_n)] == $past(reg_if.wdat[0])))
		else $error("bit write disturbed other latch bits");

	a_read_pins: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.take && !reg_if.we && lat_hit[0] && !reg_if.tag) |=>
		(wb_ack_o && wb_dat_o == {24'h000000, $past(pin_rd[7:0])}))
		else $error("plain read did not return pin levels");

	a_rmw_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.take && !reg_if.we && lat_hit[0] && reg_if.tag) |=>
		(wb_ack_o && wb_dat_o == {24'h000000, $past(latch_q[7:0])}))
		else $error("latch view read did not return the latch");

	a_xbar_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!xbar_en |-> (pad_oe_o == '0))
		else $error("driver on while crossbar disabled");

	a_xbar_wake: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.wr && crossbar_control_1_hit && reg_if.wdat[`PCX_CROSSBAR_CONTROL_1_CROSSBAR_ENABLE]) |=> crossbar_enable_o)
		else $error("crossbar enable write ignored");

	// routing bits are passed on exactly as written
	a_route_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.wr && crossbar_control_1_hit) |=> (crossbar_routing_o == $past(reg_if.wdat[5:0])))
		else $error("routing bits do not follow the control write");

	// pullup disable switches every pullup off at once
	a_pullup_global: assert property (@(posedge clk_i) disable iff (rst_i)
		wpud |-> (pad_pullup_o == '0))
		else $error("pullup on while globally disabled");

	// a write whose low lane is not selected leaves the latch alone
	a_lane_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && !wb_sel_i[0] && lat_hit[0]) |=>
		(latch_q[7:0] == $past(latch_q[7:0])))
		else $error("latch changed by a write without lane zero");

	// tagged single-bit read returns the latch bit
	a_bit_rmw_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.take && !reg_if.we && bit_hit[0] && reg_if.tag) |=>
		(wb_ack_o && wb_dat_o == {31'h00000000, $past(latch_q[bit_n])}))
		else $error("latch view bit read did not return the latch bit");

	// an analog pin reads as one on a plain port read
	a_analog_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.take && !reg_if.we && lat_hit[0] && !reg_if.tag && !kind_q[0]) |=> wb_dat_o[0])
		else $error("analog pin did not read as one");

	// an unmapped index reads as zero
	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_if.take && !reg_if.we && reg_if.idx == 10'h000) |=> (wb_dat_o == 32'h00000000))
		else $error("unmapped read not zero");

	// every port: byte writes land in its own latch and mode registers
	generate
		for (genvar p = 0; p < NPORTS; p++) begin : g_chk
			a_port_latch: assert property (@(posedge clk_i) disable iff (rst_i)
				(reg_if.wr && lat_hit[p]) |=> (latch_q[p*8 +: 8] == $past(reg_if.wdat)))
				else $error("port latch write lost");
			a_port_kind: assert property (@(posedge clk_i) disable iff (rst_i)
				(reg_if.wr && kind_hit[p]) |=> (kind_q[p*8 +: 8] == $past(reg_if.wdat)))
				else $error("input kind write lost");
			a_port_drive: assert property (@(posedge clk_i) disable iff (rst_i)
				(reg_if.wr && drive_hit[p]) |=> (drive_q[p*8 +: 8] == $past(reg_if.wdat)))
				else $error("drive mode write lost");
		end
	endgenerate
endmodule : pcx_port_top

//--- tb/pcx_pad_model.sv
// pad model: the circuitry outside the port pins
// assumes the bench says where the outside drives and with what level
`timescale 1ns/10ps
module pcx_pad_model (
	input wire logic clk_i, // system clock
	input wire logic [31:0] out_i, // device pad value
	input wire logic [31:0] oe_i, // device drives the pin
	input wire logic [31:0] pu_i, // weak pullup on
	input wire logic [31:0] ext_en_i, // outside drives where the device does not
	input wire logic [31:0] ext_val_i, // outside level
	output logic [31:0] pad_o // resolved pin level
);
	logic [31:0] flt_q = 32'h5555_5555; // level of undriven pins

	// undriven pins wander every cycle so no stale level can pass
	always @(posedge clk_i) begin
		flt_q <= ~flt_q;
	end

	// device wins, then the outside, then the pullup, else floating
	assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & pu_i)
		| (~oe_i & ~ext_en_i & ~pu_i & flt_q);
endmodule : pcx_pad_model

//--- tb/port_latch_and_crossbar_enable_test.sv
// self-checking bench for the port latch and crossbar block
// assumes a 40 MHz clock and a classic wishbone master in the bench
`timescale 1ns/10ps
module port_latch_and_crossbar_enable_test;
	import pcx_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_tga_i = 1'b0, wb_ack_o, crossbar_enable_o;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [5:0] crossbar_routing_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pad_out_o, pad_oe_o, pad_pullup_o, pad_in;
	logic [31:0] psel = 32'h0, pdat = 32'h0, ext_en = 32'h0, ext_val = 32'h0;
	logic [31:0] e_oe, e_out, e_pu, e_pin, e_known, q, r, x;
	pcx_byte_t m_lat[4], m_drv[4], m_knd[4], m_xbr;
	int mismatches = 0, comparisons = 0, cycles = 0, seed = 30116, p, n;

	// ----------------------------------------------------------------
	// design and pins
	// ----------------------------------------------------------------
	always #12.5 clk_i = ~clk_i;
	pcx_port_top #(.NPORTS(4)) i_pcx_port_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_tga_i(wb_tga_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in_i(pad_in), .pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o), .periph_sel_i(psel), .periph_dat_i(pdat),
		.crossbar_enable_o(crossbar_enable_o), .crossbar_routing_o(crossbar_routing_o));
	pcx_pad_model i_pcx_pad_model (.clk_i(clk_i), .out_i(pad_out_o), .oe_i(pad_oe_o), .pu_i(pad_pullup_o),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one classic cycle; holds everything until ack, read data taken at that edge
	task automatic wb(input logic we, input logic tga, input logic [9:0] idx, input pcx_byte_t d,
		input logic [3:0] sel);
		int k;
		logic [31:0] hi;
		k = 0;
		hi = $random(seed);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_tga_i <= tga;
		wb_adr_i <= {idx, 2'h0};
		wb_sel_i <= sel;
		wb_dat_i <= {hi[23:0], d};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (k == 20) begin
			mismatches++;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// expected pad outputs and pin levels from the register model
	task automatic model_pads();
		logic v, dg, pp;
		for (int k = 0; k < 32; k++) begin
			dg = m_knd[k / 8][k % 8];
			pp = m_drv[k / 8][k % 8];
			v = psel[k] ? pdat[k] : m_lat[k / 8][k % 8];
			e_oe[k] = m_xbr[6] & dg & (pp | ~v);
			e_out[k] = pp & v;
			e_pu[k] = ~m_xbr[7] & dg & ~pp & ~e_oe[k];
			e_known[k] = e_oe[k] | ext_en[k] | e_pu[k] | ~dg;
			e_pin[k] = ~dg | (e_oe[k] ? e_out[k] : (ext_en[k] ? ext_val[k] : 1'b1));
		end
	endtask : model_pads

	// pads after settling, then every register through the bus
	task automatic check_all();
		model_pads();
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk(pad_oe_o, e_oe);
		chk(pad_out_o & e_oe, e_out & e_oe);
		chk(pad_pullup_o, e_pu);
		chk({25'h0, crossbar_enable_o, crossbar_routing_o}, {25'h0, m_xbr[6:0]});
		@(posedge clk_i);
		for (int k = 0; k < 4; k++) begin
			wb(1'b0, 1'b0, 10'(128 + k * 16), 8'h00, 4'hF);
			chk(q & {24'hFFFFFF, e_known[k*8+:8]}, {24'h0, e_pin[k*8+:8] & e_known[k*8+:8]});
			wb(1'b0, 1'b1, 10'(128 + k * 16), 8'h00, 4'hF);
			chk(q, {24'h0, m_lat[k]});
			wb(1'b0, 1'b0, 10'(164 + k), 8'h00, 4'hF);
			chk(q, {24'h0, m_drv[k]});
			wb(1'b0, 1'b0, 10'(241 + k), 8'h00, 4'hF);
			chk(q, {24'h0, m_knd[k]});
		end
		wb(1'b0, 1'b0, 10'h0E2, 8'h00, 4'hF);
		chk(q, {24'h0, m_xbr});
	endtask : check_all

	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int k = 0; k < 4; k++) begin
			m_lat[k] = 8'hFF;
			m_drv[k] = 8'h00;
			m_knd[k] = 8'hFF;
		end
		m_xbr = 8'h00;
		check_all();
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			x = $random(seed);
			p = r[1:0];
			n = r[4:2];
			psel <= $random(seed) & $random(seed);
			pdat <= $random(seed);
			ext_en <= $random(seed);
			ext_val <= $random(seed);
			m_xbr = (i < 4) ? {x[7], 1'b0, x[5:0]} : x[7:0];
			wb(1'b1, 1'b0, 10'h0E2, m_xbr, 4'h1);
			m_lat[p] = x[15:8];
			wb(1'b1, 1'b0, 10'(128 + p * 16), m_lat[p], 4'h1);
			m_drv[p] = (i < 4) ? 8'hFF : x[23:16];
			wb(1'b1, 1'b0, 10'(164 + p), m_drv[p], 4'h1);
			m_knd[p] = (i % 3 == 0) ? x[31:24] : 8'hFF;
			wb(1'b1, 1'b0, 10'(241 + p), m_knd[p], 4'h1);
			m_lat[p][n] = r[5];
			wb(1'b1, 1'b0, 10'(384 + p * 16 + n), {7'h0, r[5]}, 4'h1);
			wb(1'b1, 1'b0, 10'(128 + p * 16), ~m_lat[p], 4'hE);
			check_all();
			wb(1'b0, 1'b1, 10'(384 + p * 16 + n), 8'h00, 4'hF);
			chk(q, {31'h0, m_lat[p][n]});
			wb(1'b0, 1'b0, 10'(384 + p * 16 + n), 8'h00, 4'hF);
			chk(q & {31'h7FFFFFFF, e_known[p*8+n]}, {31'h0, e_pin[p*8+n] & e_known[p*8+n]});
			$display("test random %0d done", i);
		end
		wb(1'b1, 1'b0, 10'h000, 8'hA5, 4'hF);
		wb(1'b0, 1'b0, 10'h000, 8'h00, 4'hF);
		chk(q, 32'h0);
		wb(1'b0, 1'b1, 10'h3FF, 8'h00, 4'hF);
		chk(q, 32'h0);
		check_all();
		$display("test unmapped done");
		summarize();
	end
endmodule : port_latch_and_crossbar_enable_test
